// ==== pkg/sca_pkg.sv ====
// Shared limits and defaults for the streaming channel adapter.
// Assumes a single clock domain; nothing here is software visible.
package sca_pkg;
  localparam int SCA_CH_W_MAX     = 8;
  localparam int SCA_MAX_CH_LIMIT = 255;
  localparam int SCA_ERR_W_MAX    = 31;
  localparam int SCA_DEF_CH_W     = 4;
  localparam int SCA_DEF_MAX_CH   = 15;
  localparam int SCA_DEF_BPS      = 8;
  localparam int SCA_DEF_SPB      = 4;
  localparam int SCA_DEF_ERR_W    = 1;
  localparam int SCA_DEF_EMPTY_W  = 2;
  localparam int SCA_DEF_RDY_LAT  = 0;
  localparam logic [7:0] SCA_CH_ZERO = 8'h00;
endpackage

// ==== design/sca_channel_adapter.sv ====
// Streaming channel adapter between one source and one sink core.
// Assumes both cores share core_clk; ready latency is set by the cores.
// How it works
// - Sink without channels: flag error for any nonzero source channel.
// - Source without channels: sink channel driven to all zeros.
// - Narrower source channel is forwarded, extra sink bits are zero.
// - Wider source channel is forwarded in its low bits, the rest dropped.
// - Error flagged whenever a valid beat's channel exceeds the sink maximum.
// - Valid to the sink held low for out-of-range channels.
// - Channel widths are parameters from zero to eight; zero means absent.
// - Highest channel per side is a parameter from 0 to 255.
// - Optional ready with a fixed latency shared by both sides.
// - Optional packet framing signals carried straight through.
// - Error field width is a shared parameter 0 to 31; zero absent.
// - Symbol size and symbols per beat are shared; data layout unchanged.
// - No registers, no interrupts; all behaviour fixed by parameters.
`timescale 1ns/1ps
module sca_channel_adapter
  import sca_pkg::*;
#(
  parameter int SRC_CH_W   = SCA_DEF_CH_W,
  parameter int SNK_CH_W   = SCA_DEF_CH_W,
  parameter int SRC_MAX_CH = SCA_DEF_MAX_CH,
  parameter int SNK_MAX_CH = SCA_DEF_MAX_CH,
  parameter int BPS        = SCA_DEF_BPS,
  parameter int SPB        = SCA_DEF_SPB,
  parameter int USE_READY  = 1,
  parameter int RDY_LAT    = SCA_DEF_RDY_LAT,
  parameter int USE_PKT    = 1,
  parameter int EMPTY_W    = SCA_DEF_EMPTY_W,
  parameter int ERR_W      = SCA_DEF_ERR_W
) (
  // Clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    resetn,
  // Source side, into the adapter
  input  wire logic [BPS*SPB-1:0]                      src_data,
  input  wire logic                                    src_valid,
  output logic                                         src_ready,
  input  wire logic [(SRC_CH_W > 0 ? SRC_CH_W : 1)-1:0] src_channel,
  input  wire logic                                    src_sop,
  input  wire logic                                    src_eop,
  input  wire logic [EMPTY_W-1:0]                      src_empty,
  input  wire logic [(ERR_W > 0 ? ERR_W : 1)-1:0]      src_error,
  // Sink side, out of the adapter
  output logic [BPS*SPB-1:0]                           snk_data,
  output logic                                         snk_valid,
  input  wire logic                                    snk_ready,
  output logic [(SNK_CH_W > 0 ? SNK_CH_W : 1)-1:0]     snk_channel,
  output logic                                         snk_sop,
  output logic                                         snk_eop,
  output logic [EMPTY_W-1:0]                           snk_empty,
  output logic [(ERR_W > 0 ? ERR_W : 1)-1:0]           snk_error,
  // Status
  output logic                                         chan_err
);

  localparam int SRC_P = (SRC_CH_W > 0) ? SRC_CH_W : 1;
  localparam int SNK_P = (SNK_CH_W > 0) ? SNK_CH_W : 1;
  localparam logic [7:0] SNK_LIMIT = 8'(SNK_MAX_CH);
  // Nothing below holds state or is software visible

  logic [7:0] src_ch8;
  logic       ch_bad;

  // Reference channel mapping for the checks, worked from the pins
  function automatic logic [SNK_P-1:0] sca_exp_chan(input logic [SRC_P-1:0] ch);
    logic [15:0] wide;
    wide = 16'h0000;
    if (SRC_CH_W > 0) begin
      wide[SRC_P-1:0] = ch;
    end
    return (SNK_CH_W > 0) ? wide[SNK_P-1:0] : '0;
  endfunction

  // Reference refusal decision, also worked from the pins
  function automatic logic sca_exp_bad(input logic [SRC_P-1:0] ch);
    int ch_num;
    ch_num = (SRC_CH_W > 0) ? int'(ch) : 0;
    if (SNK_CH_W == 0) begin
      return ch_num != 0;
    end
    return ch_num > SNK_MAX_CH;
  endfunction

  // Widen the source channel to the full 8-bit range once, then judge it
  always_comb begin
    src_ch8 = SCA_CH_ZERO;
    for (int i = 0; i < SRC_P; i++) begin
      if (SRC_CH_W > 0 && i < SCA_CH_W_MAX) begin
        src_ch8[i] = src_channel[i];
      end
    end
  end

  always_comb begin
    if (SNK_CH_W == 0) begin
      ch_bad = (src_ch8 != SCA_CH_ZERO);
    end else begin
      ch_bad = (src_ch8 > SNK_LIMIT);
    end
  end

  // Purely combinational so the ready latency seen by both cores is equal;
  // registering here would add a beat of latency and break that contract.
  always_comb begin
    snk_channel = '0;
    for (int i = 0; i < SNK_P; i++) begin
      if (SNK_CH_W > 0 && i < SCA_CH_W_MAX) begin
        snk_channel[i] = src_ch8[i];
      end
    end
  end

  assign src_ready = (USE_READY != 0) ? snk_ready : 1'b1;
  assign snk_valid = src_valid & ~ch_bad;
  assign chan_err  = src_valid & ch_bad;
  assign snk_data  = src_data;
  assign snk_sop   = (USE_PKT != 0) ? src_sop : 1'b0;
  assign snk_eop   = (USE_PKT != 0) ? src_eop : 1'b0;
  assign snk_empty = (USE_PKT != 0) ? src_empty : '0;
  assign snk_error = (ERR_W > 0) ? src_error : '0;

  property p_params;
    @(posedge core_clk) disable iff (!resetn)
      1'b1 |-> (SRC_CH_W <= SCA_CH_W_MAX && SNK_CH_W <= SCA_CH_W_MAX && SRC_CH_W >= 0 && SNK_CH_W >= 0);
  endproperty
  a_params: assert property (p_params) else $error("Channel width out of range");

  property p_maxch;
    @(posedge core_clk) disable iff (!resetn)
      1'b1 |-> (SRC_MAX_CH <= SCA_MAX_CH_LIMIT && SNK_MAX_CH <= SCA_MAX_CH_LIMIT && ERR_W <= SCA_ERR_W_MAX);
  endproperty
  a_maxch: assert property (p_maxch) else $error("Max channel or error width out of range");

  property p_nochan_err;
    @(posedge core_clk) disable iff (!resetn)
      (SNK_CH_W == 0 && SRC_CH_W > 0 && src_valid && src_channel != '0) |-> (chan_err && !snk_valid);
  endproperty
  a_nochan_err: assert property (p_nochan_err) else $error("Nonzero channel passed to channelless sink");

  property p_zero_fill;
    @(posedge core_clk) disable iff (!resetn)
      (SRC_CH_W == 0) |-> (snk_channel == '0);
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("Sink channel not zero filled");

  property p_low_bits;
    @(posedge core_clk) disable iff (!resetn)
      (SRC_CH_W > 0 && SNK_CH_W > 0) |-> (snk_channel == SNK_P'(src_ch8));
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("Sink channel differs from source low bits");

  property p_range;
    @(posedge core_clk) disable iff (!resetn)
      (SNK_CH_W > 0 && src_valid && src_ch8 > SNK_LIMIT) |-> (chan_err && !snk_valid);
  endproperty
  a_range: assert property (p_range) else $error("Out-of-range channel not blocked");

  property p_pass;
    @(posedge core_clk) disable iff (!resetn)
      (src_valid && !chan_err) |-> (snk_valid && snk_data == src_data);
  endproperty
  a_pass: assert property (p_pass) else $error("Legal beat not forwarded");

  property p_err_beat;
    @(posedge core_clk) disable iff (!resetn)
      chan_err |-> (src_valid && !snk_valid);
  endproperty
  a_err_beat: assert property (p_err_beat) else $error("Channel error outside an offending beat");

  property p_ready;
    @(posedge core_clk) disable iff (!resetn)
      (USE_READY != 0) |-> (src_ready == snk_ready);
  endproperty
  a_ready: assert property (p_ready) else $error("Ready not passed through");

  property p_pkt;
    @(posedge core_clk) disable iff (!resetn)
      (USE_PKT != 0 && src_valid) |-> (snk_sop == src_sop && snk_eop == src_eop && snk_empty == src_empty);
  endproperty
  a_pkt: assert property (p_pkt) else $error("Packet framing not carried");

  // Checks below judge the pins, some against the reference functions, not ch_bad
  property p_chan_map;
    @(posedge core_clk) disable iff (!resetn)
      src_valid |-> (snk_channel == sca_exp_chan(src_channel));
  endproperty
  a_chan_map: assert property (p_chan_map) else $error("Sink channel mapping wrong");

  property p_upper_zero;
    @(posedge core_clk) disable iff (!resetn)
      (SRC_CH_W > 0 && SNK_CH_W > SRC_CH_W) |-> ((snk_channel >> SRC_P) == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Extra sink channel bits not zero");

  property p_exp_err;
    @(posedge core_clk) disable iff (!resetn)
      src_valid |-> (chan_err == sca_exp_bad(src_channel));
  endproperty
  a_exp_err: assert property (p_exp_err) else $error("Channel error decision wrong");

  property p_exp_valid;
    @(posedge core_clk) disable iff (!resetn)
      src_valid |-> (snk_valid == !sca_exp_bad(src_channel));
  endproperty
  a_exp_valid: assert property (p_exp_valid) else $error("Sink valid decision wrong");

  property p_idle;
    @(posedge core_clk) disable iff (!resetn)
      !src_valid |-> (!snk_valid && !chan_err);
  endproperty
  a_idle: assert property (p_idle) else $error("Output active without a source beat");

  property p_zero_ok;
    @(posedge core_clk) disable iff (!resetn)
      (SNK_CH_W == 0 && src_valid && src_channel == '0) |-> (snk_valid && !chan_err);
  endproperty
  a_zero_ok: assert property (p_zero_ok) else $error("Channel zero refused by channelless sink");

  property p_nosrc_ok;
    @(posedge core_clk) disable iff (!resetn)
      (SRC_CH_W == 0 && SNK_CH_W > 0 && src_valid) |-> (snk_valid && !chan_err);
  endproperty
  a_nosrc_ok: assert property (p_nosrc_ok) else $error("Beat from channelless source refused");

  property p_nosnk_chan;
    @(posedge core_clk) disable iff (!resetn)
      (SNK_CH_W == 0) |-> (snk_channel == '0);
  endproperty
  a_nosnk_chan: assert property (p_nosnk_chan) else $error("Absent sink channel not quiet");

  property p_data;
    @(posedge core_clk) disable iff (!resetn)
      src_valid |-> (snk_data == src_data);
  endproperty
  a_data: assert property (p_data) else $error("Beat data changed on the way");

  property p_err_copy;
    @(posedge core_clk) disable iff (!resetn)
      (ERR_W > 0 && src_valid) |-> (snk_error == src_error);
  endproperty
  a_err_copy: assert property (p_err_copy) else $error("Error field not carried");

  property p_err_none;
    @(posedge core_clk) disable iff (!resetn)
      (ERR_W == 0) |-> (snk_error == '0);
  endproperty
  a_err_none: assert property (p_err_none) else $error("Absent error field not quiet");

  property p_pkt_off;
    @(posedge core_clk) disable iff (!resetn)
      (USE_PKT == 0) |-> (!snk_sop && !snk_eop && snk_empty == '0);
  endproperty
  a_pkt_off: assert property (p_pkt_off) else $error("Framing driven with packets off");

  property p_ready_tied;
    @(posedge core_clk) disable iff (!resetn)
      (USE_READY == 0) |-> src_ready;
  endproperty
  a_ready_tied: assert property (p_ready_tied) else $error("Ready low with backpressure off");

  property p_ready_rose;
    @(posedge core_clk) disable iff (!resetn)
      (USE_READY != 0 && $rose(snk_ready)) |-> src_ready;
  endproperty
  a_ready_rose: assert property (p_ready_rose) else $error("Ready rise delayed toward source");

  property p_same_beat;
    @(posedge core_clk) disable iff (!resetn)
      (src_valid && !$past(src_valid)) |-> (snk_valid || chan_err);
  endproperty
  a_same_beat: assert property (p_same_beat) else $error("New beat not seen in its own cycle");

  property p_bps;
    @(posedge core_clk) disable iff (!resetn)
      1'b1 |-> (BPS > 0 && SPB > 0 && $bits(snk_data) == BPS * SPB);
  endproperty
  a_bps: assert property (p_bps) else $error("Symbol layout parameters unusable");

  property p_one_of;
    @(posedge core_clk) disable iff (!resetn)
      src_valid |-> (snk_valid != chan_err);
  endproperty
  a_one_of: assert property (p_one_of) else $error("Beat neither forwarded nor flagged alone");

  property p_max_fit;
    @(posedge core_clk) disable iff (!resetn)
      (SNK_CH_W > 0) |-> (SNK_MAX_CH < (1 << SNK_CH_W));
  endproperty
  a_max_fit: assert property (p_max_fit) else $error("Sink maximum does not fit its width");

  property p_trunc;
    @(posedge core_clk) disable iff (!resetn)
      (SRC_CH_W > SNK_CH_W && SNK_CH_W > 0 && src_valid && (src_channel >> SNK_P) != '0) |-> chan_err;
  endproperty
  a_trunc: assert property (p_trunc) else $error("Dropped channel bits not flagged");

  property p_clear_after;
    @(posedge core_clk) disable iff (!resetn)
      (chan_err ##1 !src_valid) |-> !chan_err;
  endproperty
  a_clear_after: assert property (p_clear_after) else $error("Channel error outlived its beat");

endmodule

// ==== sim/sca_sink_model.sv ====
// Sink core model: stalls in a fixed pattern, counts beats it takes.
// Assumes ready latency zero, beats taken at the core_clk rise.
`timescale 1ns/1ps
module sca_sink_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Stream
  input  wire logic snk_valid,
  output logic      snk_ready,
  output int        n_taken
);
  logic [2:0] pat_reg;
  assign snk_ready = pat_reg[0];
  // Pattern restarts on reset so the stall sequence is repeatable
  always @(posedge core_clk) begin
    if (!resetn) begin
      pat_reg <= 3'h5;
      n_taken <= 0;
    end else begin
      pat_reg <= {pat_reg[1:0], pat_reg[2] ^ pat_reg[1]};
      if (snk_valid && snk_ready) n_taken <= n_taken + 1;
    end
  end
endmodule

// ==== sim/stream_channel_adapter_bench.sv ====
// Bench: random beats from an 8-bit source into a 4-bit sink.
// Assumes sink maximum 9, so higher channels must be refused.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("mismatch at %0t: output differs", $time); end end
module stream_channel_adapter_bench;
  localparam int SMAX = 9;
  logic        core_clk = 0, resetn = 0, src_valid = 0, src_sop = 0, src_eop = 0, src_error = 0;
  logic [31:0] src_data = '0, lfsr = 32'h6681, snk_data;
  logic [7:0]  src_channel = '0;
  logic [1:0]  src_empty = '0, snk_empty;
  logic [3:0]  snk_channel;
  logic        src_ready, snk_valid, snk_ready, snk_sop, snk_eop, snk_error, chan_err;
  int          n_fail = 0, checks_done = 0, n_exp = 0, n_taken;
  logic        stall = 0, nc_valid, nc_err, nc_chan, ns_valid, ns_err, wd_valid, wd_err;
  logic [3:0]  ns_chan;
  logic [7:0]  wd_chan;
  logic [7:0]  corner [7] = '{8'h00, 8'h09, 8'h0a, 8'h0f, 8'h10, 8'h19, 8'hff};
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic bad_ch(input logic [7:0] c);
    return c > SMAX;
  endfunction
  sca_channel_adapter #(.SRC_CH_W(8), .SNK_CH_W(4), .SRC_MAX_CH(255), .SNK_MAX_CH(SMAX)) dut (
    .core_clk, .resetn, .src_data, .src_valid, .src_ready, .src_channel, .src_sop, .src_eop,
    .src_empty, .src_error, .snk_data, .snk_valid, .snk_ready, .snk_channel, .snk_sop,
    .snk_eop, .snk_empty, .snk_error, .chan_err);
  sca_sink_model sink (.core_clk, .resetn, .snk_valid, .snk_ready, .n_taken);
  // Channelless sink, channelless source and narrow-into-wide variants
  sca_channel_adapter #(.SRC_CH_W(8), .SNK_CH_W(0), .SRC_MAX_CH(255), .SNK_MAX_CH(0)) dut_nosnk (
    .core_clk, .resetn, .src_data, .src_valid, .src_ready(), .src_channel, .src_sop, .src_eop,
    .src_empty, .src_error, .snk_data(), .snk_valid(nc_valid), .snk_ready, .snk_channel(nc_chan),
    .snk_sop(), .snk_eop(), .snk_empty(), .snk_error(), .chan_err(nc_err));
  sca_channel_adapter #(.SRC_CH_W(0), .SNK_CH_W(4), .SRC_MAX_CH(0), .SNK_MAX_CH(15)) dut_nosrc (
    .core_clk, .resetn, .src_data, .src_valid, .src_ready(), .src_channel(src_channel[0]), .src_sop,
    .src_eop, .src_empty, .src_error, .snk_data(), .snk_valid(ns_valid), .snk_ready, .snk_channel(ns_chan),
    .snk_sop(), .snk_eop(), .snk_empty(), .snk_error(), .chan_err(ns_err));
  sca_channel_adapter #(.SRC_CH_W(4), .SNK_CH_W(8), .SRC_MAX_CH(15), .SNK_MAX_CH(255)) dut_wide (
    .core_clk, .resetn, .src_data, .src_valid, .src_ready(), .src_channel(src_channel[3:0]), .src_sop,
    .src_eop, .src_empty, .src_error, .snk_data(), .snk_valid(wd_valid), .snk_ready, .snk_channel(wd_chan),
    .snk_sop(), .snk_eop(), .snk_empty(), .snk_error(), .chan_err(wd_err));
  always #20 core_clk = ~core_clk;
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Outputs are combinational, so check mid-cycle once inputs settle
  always @(negedge core_clk) if (resetn) begin
    `CHK(snk_valid, src_valid & ~bad_ch(src_channel))
    `CHK(chan_err, src_valid & bad_ch(src_channel))
    `CHK(snk_channel, src_channel[3:0])
    `CHK(src_ready, snk_ready)
    `CHK(snk_data, src_data)
    `CHK({snk_sop, snk_eop, snk_empty}, {src_sop, src_eop, src_empty})
    `CHK(snk_error, src_error)
    `CHK({nc_valid, nc_chan}, {src_valid & (src_channel == 8'h00), 1'b0})
    `CHK(nc_err, src_valid & (src_channel != 8'h00))
    `CHK({ns_valid, ns_err, ns_chan}, {src_valid, 1'b0, 4'h0})
    `CHK({wd_valid, wd_err, wd_chan}, {src_valid, 1'b0, 4'h0, src_channel[3:0]})
    if (snk_valid === 1'b1 && snk_ready === 1'b1) n_exp++;
    // Source must hold an offered beat until ready takes it
    stall = src_valid & ~src_ready;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      while (stall) @(posedge core_clk);
      lfsr = lfsr_step(lfsr);
      // Back-to-back corners first, then a mix of in- and out-of-range
      src_valid   <= lfsr[0] | (i < 14);
      src_channel <= (i < 14) ? corner[i % 7] : (lfsr[4] ? {4'h0, lfsr[11:8]} : lfsr[15:8]);
      src_data    <= lfsr_step(lfsr);
      {src_sop, src_eop, src_empty, src_error} <= lfsr[24:20];
    end
    @(posedge core_clk);
    #1;
    `CHK(n_taken, n_exp)
    stop_test();
  end
  initial begin
    #(40 * 2000);
    n_fail++;
    stop_test();
  end
endmodule
